// ---- inc/lfdw_pkg.sv ----
// package for the frame-buffer depth write unpacker
package lfdw_pkg;
    // write configuration fields
    localparam int FMT_LSB = 0;
    localparam int FMT_W = 4;
    localparam int CHORD_LSB = 9;
    localparam int PIPE_EN_BIT = 8;
    localparam logic [3:0] FMT_HOSTPORT = 4'h9;
    localparam logic [3:0] FMT_RSVD_A = 4'ha;
    localparam logic [3:0] FMT_RSVD_B = 4'hb;
    localparam logic [3:0] FMT_Z_565 = 4'hc;
    localparam logic [3:0] FMT_Z_555 = 4'hd;
    localparam logic [3:0] FMT_Z_1555 = 4'he;
    localparam logic [3:0] FMT_Z_Z = 4'hf;
    // render configuration and constant alpha fields
    localparam int DEPTH_MODE_LSB = 0;
    localparam logic [1:0] BPP_15 = 2'h1;
    localparam logic [1:0] BPP_32 = 2'h2;
    localparam int ALPHA_SEL_LSB = 15;
    localparam logic [1:0] ALPHA_SEL_ZERO = 2'h0;
    localparam logic [1:0] ALPHA_SEL_ONE = 2'h1;
    localparam logic [1:0] ALPHA_SEL_CONST = 2'h2;
    localparam int CONST_ALPHA_BIT = 31;
    localparam int CONST_ALPHA_LSB = 24;
    // enable bit of misc init
    localparam int QUEUE_EN_BIT = 31;
    // host port command word
    localparam int HP_DATA_LSB = 0;
    localparam int HP_ADDR_LSB = 8;
    localparam int HP_RW_BIT = 12;
    localparam int HP_CS_BIT = 13;
    localparam int HP_MODE_BIT = 14;
    localparam int HP_SPEED_BIT = 15;
    localparam int HP_EXEC_BIT = 16;
    // host port timing, cycles per step at full speed
    localparam int HP_STEP_CYCLES = 4;

    typedef struct packed {
        logic [7:0] data;
        logic [3:0] addr;
        logic rw;
        logic cs_n;
        logic mode_b;
        logic half_speed;
        logic execute;
    } lfdw_hp_cmd_t;

    typedef struct packed {
        logic [7:0] data;
        logic [3:0] addr;
        logic rw;
        logic cs_n;
        logic strobe;
    } lfdw_hp_pins_t;

    typedef struct packed {
        logic [23:0] depth;
        logic depth_is_16;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic [7:0] alpha;
        logic alpha_bit;
        logic color_valid;
    } lfdw_fb_word_t;

    typedef struct packed {
        logic [23:0] z_int;
        logic [7:0] z_frac;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic [7:0] alpha;
    } lfdw_pipe_word_t;
endpackage

// ---- hw/lfdw_hostport.sv ----
// host port write sequencer for queued command words
`timescale 1ns/1ps
module lfdw_hostport #(
    parameter int STEP_CYCLES = lfdw_pkg::HP_STEP_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // command in
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire lfdw_pkg::lfdw_hp_cmd_t cmd,
    // pins
    output lfdw_pkg::lfdw_hp_pins_t pins,
    output logic busy
);
    typedef enum logic [1:0] {LFDW_IDLE, LFDW_SETUP, LFDW_STROBE, LFDW_HOLD} lfdw_hp_state_t;
    lfdw_hp_state_t state;
    logic [7:0] count;
    logic half;
    wire logic [7:0] step_len = half ? 8'(2 * STEP_CYCLES - 1) : 8'(STEP_CYCLES - 1);
    wire logic step_done = (count == step_len);

    assign cmd_ready = (state == LFDW_IDLE);
    assign busy = (state != LFDW_IDLE);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= LFDW_IDLE;
            count <= 8'h00;
            half <= 1'b0;
            pins <= '0;
        end else begin
            count <= (state == LFDW_IDLE || step_done) ? 8'h00 : count + 8'h01;
            unique case (state)
                LFDW_IDLE: begin
                    if (cmd_valid) begin
                        pins.data <= cmd.data;
                        pins.addr <= cmd.addr;
                        pins.rw <= cmd.rw;
                        pins.cs_n <= cmd.cs_n;
                        half <= cmd.half_speed;
                        if (cmd.execute) begin
                            state <= LFDW_SETUP;
                        end
                    end
                end
                LFDW_SETUP: begin
                    if (step_done) begin
                        state <= LFDW_STROBE;
                        pins.strobe <= 1'b1;
                    end
                end
                LFDW_STROBE: begin
                    if (step_done) begin
                        state <= LFDW_HOLD;
                        pins.strobe <= 1'b0;
                    end
                end
                LFDW_HOLD: begin
                    if (step_done) begin
                        state <= LFDW_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ---- hw/lfdw_unpack.sv ----
// depth-format frame-buffer write unpacker with queued host port writes
// What this block does
// - format 15 32bpp bypass stores word bits 31:8 into the 24-bit depth buffer.
// - pipeline enabled passes bits 31:8 as integer depth, 7:0 as fraction.
// - 15/16bpp bypass stores bits 31:16 into the 16-bit depth buffer.
// - write config bit 8 set routes writes through the pixel pipeline.
// - formats 10 and 11 are unsupported and produce no writes.
// - format 12 decodes 5-6-5 colour; odd orders swap red and blue.
// - formats 12 and 13 through pipeline take alpha from constant register.
// - 15bpp bypass alpha bit is zero, one, or constant bit 31, for all formats except 14.
// - 32bpp widens 16-bit depth by appending its top 8 bits below.
// - format 13 decodes 5-5-5 colour, bit position depends on order.
// - format 14 alpha bit from 15 or 0, replicated to 8 bits.
// - format 15 through pipeline uses constant colour and constant alpha.
// - format 9 writes no frame buffer, no pipeline, ignores other config.
// - format 9 ignores address and uses only the data word.
// - format 9 word fields: data, address, rw, cs, mode, speed, execute.
// - speed bit set runs the host port sequencer at half rate.
// - execute set writes; clear only updates the port levels.
// - queued port drives pins only while misc init bit 31 is set.
`timescale 1ns/1ps
module lfdw_unpack #(
    parameter int STEP_CYCLES = lfdw_pkg::HP_STEP_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // configuration
    input wire logic [31:0] fb_write_config,
    input wire logic [31:0] render_config,
    input wire logic [31:0] constant_depth_alpha,
    input wire logic [31:0] constant_colour_one,
    input wire logic [31:0] misc_init_zero,
    input wire lfdw_pkg::lfdw_hp_pins_t serial_parallel_port_ctrl,
    // host write
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [31:0] wr_addr,
    input wire logic [31:0] wr_data,
    // frame buffer side, bypass
    output logic fb_valid,
    output logic [31:0] fb_addr,
    output lfdw_pkg::lfdw_fb_word_t fb_word,
    // pixel pipeline side
    output logic pipe_valid,
    output logic [31:0] pipe_addr,
    output lfdw_pkg::lfdw_pipe_word_t pipe_word,
    // video module host port
    output lfdw_pkg::lfdw_hp_pins_t host_port,
    output logic host_port_busy
);
    // ==========================================
    // configuration decode
    wire logic [3:0] fmt = fb_write_config[lfdw_pkg::FMT_LSB +: lfdw_pkg::FMT_W];
    wire logic [1:0] chord = fb_write_config[lfdw_pkg::CHORD_LSB +: 2];
    wire logic pipe_en = fb_write_config[lfdw_pkg::PIPE_EN_BIT];
    wire logic [1:0] depth_mode = render_config[lfdw_pkg::DEPTH_MODE_LSB +: 2];
    wire logic [1:0] alpha_sel = render_config[lfdw_pkg::ALPHA_SEL_LSB +: 2];
    wire logic is_32bpp = (depth_mode == lfdw_pkg::BPP_32);
    wire logic is_15bpp = (depth_mode == lfdw_pkg::BPP_15);
    wire logic queue_en = misc_init_zero[lfdw_pkg::QUEUE_EN_BIT];
    wire logic is_hp = (fmt == lfdw_pkg::FMT_HOSTPORT);
    wire logic is_rsvd = (fmt == lfdw_pkg::FMT_RSVD_A) || (fmt == lfdw_pkg::FMT_RSVD_B);
    wire logic is_depth_fmt = (fmt >= lfdw_pkg::FMT_Z_565);
    wire logic order_swap = chord[0];
    wire logic order_hi = chord[1];

    // ==========================================
    // host port command path
    logic hp_ready;
    lfdw_pkg::lfdw_hp_pins_t queued_pins;
    logic queued_busy;
    lfdw_pkg::lfdw_hp_cmd_t hp_cmd;
    assign hp_cmd.data = wr_data[lfdw_pkg::HP_DATA_LSB +: 8];
    assign hp_cmd.addr = wr_data[lfdw_pkg::HP_ADDR_LSB +: 4];
    assign hp_cmd.rw = wr_data[lfdw_pkg::HP_RW_BIT];
    assign hp_cmd.cs_n = wr_data[lfdw_pkg::HP_CS_BIT];
    assign hp_cmd.mode_b = wr_data[lfdw_pkg::HP_MODE_BIT];
    assign hp_cmd.half_speed = wr_data[lfdw_pkg::HP_SPEED_BIT];
    assign hp_cmd.execute = wr_data[lfdw_pkg::HP_EXEC_BIT];
    // format 9 stalls the host while a port write is running
    wire logic hp_take = wr_valid && is_hp && queue_en;
    assign wr_ready = is_hp && queue_en ? hp_ready : 1'b1;

    lfdw_hostport #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_hostport (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .cmd_valid(hp_take),
        .cmd_ready(hp_ready),
        .cmd(hp_cmd),
        .pins(queued_pins),
        .busy(queued_busy)
    );
    assign host_port = queue_en ? queued_pins : serial_parallel_port_ctrl;
    assign host_port_busy = queued_busy;

    // ==========================================
    // colour decode of the low half
    wire logic [15:0] lo = wr_data[15:0];
    logic [4:0] c_hi;
    logic [5:0] c_mid;
    logic [4:0] c_lo;
    logic alpha_in;
    always_comb begin
        c_hi = lo[15:11];
        c_mid = {lo[10:5]};
        c_lo = lo[4:0];
        alpha_in = 1'b0;
        if (fmt == lfdw_pkg::FMT_Z_565) begin
            c_hi = lo[15:11];
            c_mid = lo[10:5];
            c_lo = lo[4:0];
        end else if (!order_hi) begin
            c_hi = lo[14:10];
            c_mid = {lo[9:5], lo[9]};
            c_lo = lo[4:0];
            alpha_in = lo[15];
        end else begin
            c_hi = lo[15:11];
            c_mid = {lo[10:6], lo[10]};
            c_lo = lo[5:1];
            alpha_in = lo[0];
        end
    end
    wire logic [7:0] c_hi8 = {c_hi, c_hi[4:2]};
    wire logic [7:0] c_lo8 = {c_lo, c_lo[4:2]};
    wire logic [7:0] c_mid8 = (fmt == lfdw_pkg::FMT_Z_565) ? {c_mid, c_mid[5:4]} : {c_mid[5:1], c_mid[5:3]};
    wire logic [7:0] red8 = order_swap ? c_lo8 : c_hi8;
    wire logic [7:0] blue8 = order_swap ? c_hi8 : c_lo8;
    wire logic [7:0] alpha_rep = {8{alpha_in}};
    wire logic [7:0] const_alpha = constant_depth_alpha[lfdw_pkg::CONST_ALPHA_LSB +: 8];
    wire logic [7:0] pipe_alpha = (fmt == lfdw_pkg::FMT_Z_1555) ? alpha_rep : const_alpha;

    // ==========================================
    // depth placement
    wire logic [15:0] z16 = wr_data[31:16];
    wire logic [23:0] z_wide = {z16, z16[15:8]};
    logic [23:0] bypass_depth;
    always_comb begin
        if (fmt == lfdw_pkg::FMT_Z_Z || !is_32bpp) begin
            bypass_depth = is_32bpp ? wr_data[31:8] : {8'h00, z16};
        end else begin
            bypass_depth = z_wide;
        end
    end
    logic stored_alpha;
    always_comb begin
        unique case (alpha_sel)
            lfdw_pkg::ALPHA_SEL_ZERO: stored_alpha = 1'b0;
            lfdw_pkg::ALPHA_SEL_ONE: stored_alpha = 1'b1;
            lfdw_pkg::ALPHA_SEL_CONST: stored_alpha = constant_depth_alpha[lfdw_pkg::CONST_ALPHA_BIT];
            default: stored_alpha = 1'b0;
        endcase
    end
    wire logic bypass_abit = (fmt == lfdw_pkg::FMT_Z_1555) ? alpha_in : stored_alpha;

    // ==========================================
    // output words
    lfdw_pkg::lfdw_fb_word_t next_fb_word;
    lfdw_pkg::lfdw_pipe_word_t next_pipe_word;
    always_comb begin
        next_fb_word.depth = bypass_depth;
        next_fb_word.depth_is_16 = !is_32bpp;
        next_fb_word.red = red8;
        next_fb_word.green = c_mid8;
        next_fb_word.blue = blue8;
        next_fb_word.alpha = (fmt == lfdw_pkg::FMT_Z_1555) ? alpha_rep : 8'h00;
        next_fb_word.alpha_bit = is_15bpp ? bypass_abit : 1'b0;
        next_fb_word.color_valid = (fmt != lfdw_pkg::FMT_Z_Z);
        next_pipe_word.z_int = wr_data[31:8];
        next_pipe_word.z_frac = wr_data[7:0];
        next_pipe_word.alpha = pipe_alpha;
        if (fmt == lfdw_pkg::FMT_Z_Z) begin
            next_pipe_word.red = constant_colour_one[23:16];
            next_pipe_word.green = constant_colour_one[15:8];
            next_pipe_word.blue = constant_colour_one[7:0];
        end else begin
            next_pipe_word.red = red8;
            next_pipe_word.green = c_mid8;
            next_pipe_word.blue = blue8;
        end
    end
    wire logic take_px = wr_valid && is_depth_fmt && !is_hp && !is_rsvd;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fb_valid <= 1'b0;
            pipe_valid <= 1'b0;
            fb_addr <= 32'h0000_0000;
            pipe_addr <= 32'h0000_0000;
            fb_word <= '0;
            pipe_word <= '0;
        end else begin
            fb_valid <= take_px && !pipe_en;
            pipe_valid <= take_px && pipe_en;
            if (take_px) begin
                fb_addr <= wr_addr;
                pipe_addr <= wr_addr;
                fb_word <= next_fb_word;
                pipe_word <= next_pipe_word;
            end
        end
    end
endmodule

// ---- testbench/lfdw_unpack_checker.sv ----
// assertion checker for the depth write unpacker
`timescale 1ns/1ps
module lfdw_unpack_checker #(
    parameter int STEP_CYCLES = lfdw_pkg::HP_STEP_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // configuration
    input wire logic [31:0] fb_write_config,
    input wire logic [31:0] render_config,
    input wire logic [31:0] misc_init_zero,
    input wire lfdw_pkg::lfdw_hp_pins_t serial_parallel_port_ctrl,
    // host write
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [31:0] wr_data,
    // results
    input wire logic fb_valid,
    input wire lfdw_pkg::lfdw_fb_word_t fb_word,
    input wire logic pipe_valid,
    input wire lfdw_pkg::lfdw_pipe_word_t pipe_word,
    input wire lfdw_pkg::lfdw_hp_pins_t host_port,
    input wire logic host_port_busy
);
    // ==========
    // helpers
    wire take = wr_valid && wr_ready;
    wire pix = fb_write_config[3:0] >= lfdw_pkg::FMT_Z_565;
    wire pen = fb_write_config[lfdw_pkg::PIPE_EN_BIT];
    wire wide = render_config[1:0] == lfdw_pkg::BPP_32;
    wire hp = fb_write_config[3:0] == lfdw_pkg::FMT_HOSTPORT;
    wire zz = fb_write_config[3:0] == lfdw_pkg::FMT_Z_Z;
    wire own = misc_init_zero[lfdw_pkg::QUEUE_EN_BIT];
    logic [7:0] hi_cnt;
    logic half_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_cnt <= 8'h00;
            half_q <= 1'b0;
        end else begin
            hi_cnt <= host_port.strobe ? hi_cnt + 8'h01 : 8'h00;
            if (take && hp && own && wr_data[16]) begin
                half_q <= wr_data[15];
            end
        end
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // ==========
    // properties
    fb_cause_a: assert property (fb_valid |-> $past(take && pix && !pen))
        else $error("frame buffer write without bypass pixel write");
    pipe_cause_a: assert property (pipe_valid |-> $past(take && pix && pen))
        else $error("pipeline write without pipeline pixel write");
    fb_issue_a: assert property (take && pix && !pen |=> fb_valid)
        else $error("bypass pixel write lost");
    pipe_depth_a: assert property (take && zz && pen |=> pipe_valid
        && pipe_word.z_int == $past(wr_data[31:8]) && pipe_word.z_frac == $past(wr_data[7:0]))
        else $error("pipeline depth wrong");
    depth_wide_a: assert property (take && fb_write_config[3:0] == lfdw_pkg::FMT_Z_565 && !pen && wide
        |=> fb_word.depth == {$past(wr_data[31:16]), $past(wr_data[31:24])})
        else $error("widened depth wrong");
    depth_full_a: assert property (take && zz && !pen && wide |=> fb_word.depth == $past(wr_data[31:8]))
        else $error("full depth wrong");
    port_levels_a: assert property (take && hp && own |=> host_port.data == $past(wr_data[7:0])
        && host_port.addr == $past(wr_data[11:8]) && {host_port.cs_n, host_port.rw} == $past(wr_data[13:12]))
        else $error("port levels wrong");
    port_owner_a: assert property (!own |-> host_port == serial_parallel_port_ctrl)
        else $error("port not driven by serial control");
    strobe_width_a: assert property ($fell(host_port.strobe) && own
        |-> hi_cnt == (half_q ? 8'(2 * STEP_CYCLES) : 8'(STEP_CYCLES)))
        else $error("strobe width wrong");
    queue_hold_a: assert property (host_port_busy && hp && own |-> !wr_ready)
        else $error("command taken while port busy");
    no_strobe_a: assert property (take && hp && own && !wr_data[16] |=> !host_port.strobe [*4])
        else $error("strobe without execute");
endmodule
bind lfdw_unpack lfdw_unpack_checker #(.STEP_CYCLES(STEP_CYCLES)) chk (.sys_clk, .reset_n, .fb_write_config,
    .render_config, .misc_init_zero, .serial_parallel_port_ctrl, .wr_valid, .wr_ready, .wr_data, .fb_valid,
    .fb_word, .pipe_valid, .pipe_word, .host_port, .host_port_busy);

// ---- testbench/lfdw_port_model.sv ----
// behavioural video module host port listener
`timescale 1ns/1ps
module lfdw_port_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // pins from the block
    input wire lfdw_pkg::lfdw_hp_pins_t pins,
    // what was seen
    output int strobes,
    output logic [15:0] data_log,
    output logic [15:0] width_log
);
    logic [7:0] hi;
    logic prev;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobes <= 0;
            data_log <= 16'h0000;
            width_log <= 16'h0000;
            hi <= 8'h00;
            prev <= 1'b0;
        end else begin
            prev <= pins.strobe;
            if (pins.strobe && !prev) begin
                strobes <= strobes + 1;
                data_log <= {data_log[7:0], pins.data};
            end
            if (pins.strobe) begin
                hi <= hi + 8'h01;
            end else if (prev) begin
                width_log <= {width_log[7:0], hi};
                hi <= 8'h00;
            end
        end
    end
endmodule

// ---- testbench/lfdw_unpack_tb.sv ----
// self-checking bench for the depth write unpacker
`timescale 1ns/1ps
module lfdw_unpack_tb;
    localparam int STEP = 3;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] fb_write_config = 32'h0000_0000;
    logic [31:0] render_config = 32'h0000_0001;
    logic [31:0] constant_depth_alpha = 32'hC700_0000;
    logic [31:0] constant_colour_one = 32'h0012_3456;
    logic [31:0] misc_init_zero = 32'h0000_0000;
    lfdw_pkg::lfdw_hp_pins_t serial_parallel_port_ctrl = '0;
    logic wr_valid = 1'b0;
    logic [31:0] wr_addr = 32'h0000_0040;
    logic [31:0] wr_data = 32'h0000_0000;
    logic wr_ready, fb_valid, pipe_valid, host_port_busy;
    logic [31:0] fb_addr, pipe_addr;
    lfdw_pkg::lfdw_fb_word_t fb_word;
    lfdw_pkg::lfdw_pipe_word_t pipe_word;
    lfdw_pkg::lfdw_hp_pins_t host_port;
    int strobes;
    logic [15:0] data_log, width_log;
    int mismatches = 0;
    int check_count = 0;
    logic [3:0] fmts [4] = '{4'ha, 4'hb, 4'hc, 4'hf};
    always #5 sys_clk = ~sys_clk;
    lfdw_unpack #(.STEP_CYCLES(STEP)) uut (.sys_clk, .reset_n, .fb_write_config, .render_config,
        .constant_depth_alpha, .constant_colour_one, .misc_init_zero, .serial_parallel_port_ctrl, .wr_valid,
        .wr_ready, .wr_addr, .wr_data, .fb_valid, .fb_addr, .fb_word, .pipe_valid, .pipe_addr, .pipe_word,
        .host_port, .host_port_busy);
    lfdw_port_model model (.sys_clk, .reset_n, .pins(host_port), .strobes, .data_log, .width_log);
    // ==========
    // tasks
    task automatic cmp(input logic [31:0] got_v, input logic [31:0] exp_v);
        check_count++;
        if (got_v !== exp_v) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask
    task automatic wr(input logic [31:0] cfg, input logic [31:0] d);
        int n = 0;
        fb_write_config <= cfg;
        wr_data <= d;
        wr_valid <= 1'b1;
        @(posedge sys_clk);
        while (wr_ready !== 1'b1 && n < 100) begin
            n++;
            @(posedge sys_clk);
        end
        wr_valid <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic [23:0] rgb(input logic [3:0] f, input logic [1:0] o, input logic [15:0] w);
        logic [4:0] a, b, g5;
        logic [7:0] ge;
        if (f == lfdw_pkg::FMT_Z_565) begin
            {a, ge, b} = {w[15:11], w[10:5], w[10:9], w[4:0]};
        end else begin
            {a, g5, b} = o[1] ? w[15:1] : w[14:0];
            ge = {g5, g5[4:2]};
        end
        return o[0] ? {b, b[4:2], ge, a, a[4:2]} : {a, a[4:2], ge, b, b[4:2]};
    endfunction
    // ==========
    // tests
    initial begin
        #100_000;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        for (int f = 12; f <= 14; f++) begin
            for (int p = 0; p < 2; p++) begin
                for (int o = 0; o < 4; o++) begin
                    render_config <= {15'h0000, 2'((o == 3) ? 2 : o), 15'h0001};
                    wr({21'h0_0000, o[1:0], p[0], 4'h0, f[3:0]}, 32'h9A3C_35A7);
                    @(negedge sys_clk);
                    cmp({8'h00, p ? {pipe_word.red, pipe_word.green, pipe_word.blue}
                        : {fb_word.red, fb_word.green, fb_word.blue}}, {8'h00, rgb(f[3:0], o[1:0], 16'h35A7)});
                    cmp(p ? pipe_addr : fb_addr, 32'h0000_0040);
                    if (p == 1) begin
                        cmp({24'h00_0000, pipe_word.alpha}, {24'h00_0000, (f == 14) ? {8{o > 1}} : 8'hC7});
                    end else begin
                        cmp({31'h0, fb_word.alpha_bit}, {31'h0, (f == 14) ? (o > 1) : (o != 0)});
                        cmp({7'h00, fb_word.depth_is_16, fb_word.depth}, 32'h0100_9A3C);
                    end
                    @(posedge sys_clk);
                end
            end
        end
        render_config <= 32'h0000_0002;
        for (int i = 0; i < 8; i++) begin
            wr({23'h0, i[0], 4'h0, fmts[i / 2]}, 32'h8765_4321);
            @(negedge sys_clk);
            if (i == 3) begin
                cmp({7'h00, fb_word.depth_is_16, fb_word.depth}, 32'h0100_9A3C);
            end else if (i == 4) begin
                cmp({8'h00, fb_word.depth}, 32'h0087_6587);
            end else if (i == 6) begin
                cmp({fb_word.color_valid, fb_word.depth_is_16, 6'h00, fb_word.depth}, 32'h0087_6543);
            end else if (i == 7) begin
                cmp({pipe_word.red, pipe_word.green, pipe_word.blue, pipe_word.alpha}, 32'h1234_56C7);
                cmp({pipe_word.z_int, pipe_word.z_frac}, 32'h8765_4321);
            end
            @(posedge sys_clk);
        end
        misc_init_zero <= 32'h8000_0000;
        wr(32'h0000_3F09, 32'h0001_03A5);
        wr(32'h0000_0009, 32'h0001_805A);
        wr(32'h0000_0009, 32'h0000_2C3F);
        @(negedge sys_clk);
        cmp(strobes, 2);
        cmp({16'h0000, data_log}, 32'h0000_A55A);
        cmp({16'h0000, width_log}, {16'h0000, 8'(STEP), 8'(2 * STEP)});
        cmp({18'h0_0000, host_port.data, host_port.addr, host_port.rw, host_port.cs_n}, 32'h0000_0FF1);
        @(posedge sys_clk);
        serial_parallel_port_ctrl <= {8'h11, 4'h2, 3'b110};
        misc_init_zero <= 32'h0000_0000;
        wr(32'h0000_0009, 32'h0001_00EE);
        repeat (3 * STEP + 4) @(posedge sys_clk);
        @(negedge sys_clk);
        cmp(strobes, 2);
        cmp({17'h0_0000, host_port}, 32'h0000_0896);
        conclude();
    end
endmodule
